// ### rtl/igd_pkg.sv
// igd_pkg: constants, types and helper functions of the gate drive control
// assumes one 20 MHz clock; the preboost and fault reset cycle counts below are derived from it
`default_nettype none

package igd_pkg;

    localparam int CLK_PERIOD_NS   = 50;
    localparam int PREBOOST_NS     = 135;
    localparam int PREBOOST_CYC    = (PREBOOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT_RESET_NS    = 870;
    // enable must be low strictly longer than the figure
    localparam int FLT_RESET_CYC   = FLT_RESET_NS / CLK_PERIOD_NS + 1;
    localparam int DRV_FILTER_CYC  = 4;
    localparam int EN_FILTER_CYC   = 4;
    localparam int SATURATION_MONITOR_FIX_CYC   = 2;
    localparam int TL_DELAY_CYC    = 20;
    localparam int SPEED_LEVELS    = 11;
    localparam int SPEED_W         = 8;
    localparam int LEVEL_W         = 4;
    localparam int CNT_W           = 8;

    // synchroniser bit positions
    localparam int SY_NONINV   = 0;
    localparam int SY_INV      = 1;
    localparam int SY_EN       = 2;
    localparam int SY_SATURATION_MONITOR    = 3;
    localparam int SY_OC       = 4;
    localparam int SY_CS_GND   = 5;
    localparam int SY_INHIBIT  = 6;
    localparam int SY_CZ_SHORT = 7;
    localparam int SY_VZ_LO    = 8;
    localparam int SY_VZ_HI    = 9;
    localparam int SY_CORE_OK  = 10;
    localparam int SY_LREF_OK  = 11;
    localparam int SY_SEC_OK   = 12;
    localparam int SY_LINK_OK  = 13;
    localparam int SY_W        = 14;
    // inverting input idles high, everything else low
    localparam logic [SY_W-1:0] SY_RST = 14'h0002;

    // plateau strap encodings seen on the strap pins
    localparam logic [1:0] VZ_RESISTOR = 2'h0;
    localparam logic [1:0] VZ_SHORT    = 2'h1;

    typedef enum logic [1:0] {
        PL_9V3,
        PL_10V3,
        PL_11V4
    } igd_plateau_type;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_PREBOOST,
        ST_ON,
        ST_TWO_LEVEL,
        ST_SOFT_OFF
    } igd_state_type;

    // lowest code selects the highest level, 0 -> 11, max -> 1
    function automatic logic [LEVEL_W-1:0] speed_to_level(input logic [SPEED_W-1:0] code);
        logic [SPEED_W+3:0] prod;
        prod = {4'h0, code} * 12'(SPEED_LEVELS);
        return LEVEL_W'(SPEED_LEVELS) - LEVEL_W'(prod >> SPEED_W);
    endfunction : speed_to_level

    function automatic igd_plateau_type plateau_from_strap(input logic [1:0] strap);
        if (strap == VZ_RESISTOR) begin
            return PL_9V3;
        end else if (strap == VZ_SHORT) begin
            return PL_11V4;
        end else begin
            return PL_10V3;
        end
    endfunction : plateau_from_strap

endpackage : igd_pkg

`default_nettype wire

// ### rtl/igd_sync.sv
// igd_sync: two-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous levels; per-bit reset value by parameter
`default_nettype none

module igd_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            q_reg    <= RST_VAL;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;

endmodule : igd_sync

`default_nettype wire

// ### rtl/igd_filter.sv
// igd_filter: minimum pulse width filter on a synchronised level
// output follows the input only after it has been stable for thr cycles
`default_nettype none

module igd_filter #(
    parameter int   CW      = 8,
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          d,
    input  wire logic [CW-1:0] thr,
    output logic               q
);

    logic          q_reg;
    logic          q_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    always_comb begin
        q_next   = q_reg;
        cnt_next = '0;
        if (d != q_reg) begin
            if (cnt_reg + CW'(1) >= thr) begin
                q_next = d;
            end else begin
                cnt_next = cnt_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg   <= RST_VAL;
            cnt_reg <= '0;
        end else begin
            q_reg   <= q_next;
            cnt_reg <= cnt_next;
        end
    end

    assign q = q_reg;

endmodule : igd_filter

`default_nettype wire

// ### rtl/igd_gate_ctrl.sv
// igd_gate_ctrl: control logic of a single channel isolated gate driver
// assumes pins and comparator/supply flags arrive asynchronously, one 20 MHz clock
// Operation
// - with inverting input low, non-inverting input high turns on, low turns off
// - with non-inverting input high, inverting input low turns on, high turns off
// - drive pulses shorter than the minimum width are rejected
// - idle inverting input reads high, non-inverting low, transistor stays off
// - drive inputs act only while enable is high
// - enable low shuts down through the soft turn-off path
// - enable pulses shorter than the minimum width are ignored
// - enable rise with drive already active turns on without preboost
// - fault cleared on enable rise after enable low longer than 870 ns
// - fault output pulled low on desaturation or overcurrent
// - primary ready released only with core and logic reference supplies good
// - secondary ready released only with output supply and barrier link good
// - filtered desaturation, fixed then adjustable filter, triggers soft turn-off
// - inhibit strap blocks automatic turn-off but faults are still reported
// - overcurrent comparator disabled when its input is grounded
// - shorted two-level timing capacitor disables two-level turn-off
// - plateau strap selects 9.3 V, 11.4 V or 10.3 V
// - gate current setting digitised and carried to the output side
// - setting selects one of eleven levels, lowest voltage highest level
// - no drive output active while any supply is in undervoltage
`default_nettype none

module igd_gate_ctrl
    import igd_pkg::*;
#(
    parameter int DRV_FILTER = DRV_FILTER_CYC,
    parameter int EN_FILTER  = EN_FILTER_CYC,
    parameter int SATURATION_MONITOR_FIX  = SATURATION_MONITOR_FIX_CYC,
    parameter int TL_DELAY   = TL_DELAY_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  drive_in_noninv,
    input  wire logic                  drive_in_inv,
    input  wire logic                  enable_in,
    input  wire logic                  saturation_monitor,
    input  wire logic                  overcurrent_sense,
    input  wire logic                  overcurrent_sense_grounded,
    input  wire logic                  protect_inhibit,
    input  wire logic                  two_level_time_cap,
    input  wire logic [1:0]            two_level_voltage_strap,
    input  wire logic                  primary_core_supply,
    input  wire logic                  logic_ref_supply,
    input  wire logic                  secondary_undervoltage_level,
    input  wire logic                  barrier_link_ok,
    input  wire logic [igd_pkg::CNT_W-1:0]   saturation_monitor_filter_cycles,
    input  wire logic [igd_pkg::SPEED_W-1:0] speed_sample,
    input  wire logic                  speed_sample_valid,
    output logic                       gate_on_out,
    output logic                       preboost_out,
    output logic                       normal_off_out,
    output logic                       soft_shutdown_out,
    output logic                       two_level_out,
    output igd_pkg::igd_plateau_type   plateau_sel,
    output logic [igd_pkg::LEVEL_W-1:0] gate_level,
    output logic                       fault_out_n_out,
    output logic                       fault_out_n_oe,
    output logic                       primary_ready_out,
    output logic                       primary_ready_oe,
    output logic                       secondary_ready_out,
    output logic                       secondary_ready_oe
);

    import igd_pkg::*;

    if (DRV_FILTER < 1 || DRV_FILTER > 255 || EN_FILTER < 1 || EN_FILTER > 255
        || SATURATION_MONITOR_FIX < 1 || SATURATION_MONITOR_FIX > 255 || TL_DELAY < 1 || TL_DELAY > 255) begin : g_bad
        $error("igd_gate_ctrl: filter or delay count out of range 1..255");
    end

    localparam logic [CNT_W-1:0] DRV_THR   = CNT_W'(DRV_FILTER);
    localparam logic [CNT_W-1:0] EN_THR    = CNT_W'(EN_FILTER);
    localparam logic [CNT_W-1:0] SATURATION_MONITOR_THR = CNT_W'(SATURATION_MONITOR_FIX);
    localparam logic [CNT_W-1:0] TL_LAST   = CNT_W'(TL_DELAY - 1);
    localparam logic [CNT_W-1:0] PRB_LAST  = CNT_W'(PREBOOST_CYC - 1);
    localparam logic [CNT_W-1:0] FLT_CNT   = CNT_W'(FLT_RESET_CYC);

    // pin synchronisers
    logic [SY_W-1:0] pins_raw;
    logic [SY_W-1:0] pins_s;

    assign pins_raw = {barrier_link_ok, secondary_undervoltage_level, logic_ref_supply,
                       primary_core_supply, two_level_voltage_strap, two_level_time_cap,
                       protect_inhibit, overcurrent_sense_grounded, overcurrent_sense,
                       saturation_monitor, enable_in, drive_in_inv, drive_in_noninv};

    igd_sync #(
        .W       (SY_W),
        .RST_VAL (SY_RST)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pins_raw),
        .q     (pins_s)
    );

    // glitch filters
    logic noninv_f, inv_f, en_f, saturation_monitor_fix_f, saturation_monitor_f;

    igd_filter #(.CW(CNT_W), .RST_VAL(1'b0)) u_flt_noninv (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pins_s[SY_NONINV]),
        .thr   (DRV_THR),
        .q     (noninv_f)
    );

    igd_filter #(.CW(CNT_W), .RST_VAL(1'b1)) u_flt_inv (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pins_s[SY_INV]),
        .thr   (DRV_THR),
        .q     (inv_f)
    );

    igd_filter #(.CW(CNT_W), .RST_VAL(1'b0)) u_flt_en (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pins_s[SY_EN]),
        .thr   (EN_THR),
        .q     (en_f)
    );

    igd_filter #(.CW(CNT_W), .RST_VAL(1'b0)) u_flt_saturation_monitor_fix (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pins_s[SY_SATURATION_MONITOR]),
        .thr   (SATURATION_MONITOR_THR),
        .q     (saturation_monitor_fix_f)
    );

    igd_filter #(.CW(CNT_W), .RST_VAL(1'b0)) u_flt_saturation_monitor_adj (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (saturation_monitor_fix_f),
        .thr   (saturation_monitor_filter_cycles),
        .q     (saturation_monitor_f)
    );

    // decoded conditions
    logic demand, supplies_ok, fault_now, tl_enabled, en_rise, shutdown_req;

    // enable history and fault latch
    logic             en_prev_reg, en_prev_next;
    logic             demand_prev_reg, demand_prev_next;
    logic [CNT_W-1:0] en_low_cnt_reg, en_low_cnt_next;
    logic             fault_reg, fault_next;

    always_comb begin
        demand      = noninv_f & ~inv_f;
        supplies_ok = pins_s[SY_CORE_OK] & pins_s[SY_LREF_OK]
                      & pins_s[SY_SEC_OK] & pins_s[SY_LINK_OK];
        fault_now   = saturation_monitor_f | (pins_s[SY_OC] & ~pins_s[SY_CS_GND]);
        tl_enabled  = ~pins_s[SY_CZ_SHORT];
        en_rise     = en_f & ~en_prev_reg;
        shutdown_req = (fault_now | fault_reg) & ~pins_s[SY_INHIBIT];
    end

    always_comb begin
        en_prev_next     = en_f;
        demand_prev_next = demand;
        en_low_cnt_next  = en_low_cnt_reg;
        if (en_f) begin
            en_low_cnt_next = '0;
        end else if (en_low_cnt_reg < FLT_CNT) begin
            en_low_cnt_next = en_low_cnt_reg + CNT_W'(1);
        end
        fault_next = fault_reg;
        if (en_rise && en_low_cnt_reg >= FLT_CNT) begin
            fault_next = 1'b0;
        end
        if (fault_now) begin
            fault_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_prev_reg     <= 1'b0;
            demand_prev_reg <= 1'b0;
            en_low_cnt_reg  <= '0;
            fault_reg       <= 1'b0;
        end else begin
            en_prev_reg     <= en_prev_next;
            demand_prev_reg <= demand_prev_next;
            en_low_cnt_reg  <= en_low_cnt_next;
            fault_reg       <= fault_next;
        end
    end

    // switching state machine
    igd_state_type    state_reg, state_next;
    logic [CNT_W-1:0] phase_cnt_reg, phase_cnt_next;

    always_comb begin
        state_next     = state_reg;
        phase_cnt_next = phase_cnt_reg + CNT_W'(1);
        if (!supplies_ok) begin
            state_next = ST_OFF;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    if (en_f && demand && !shutdown_req) begin
                        if (en_rise && demand_prev_reg) begin
                            state_next = ST_ON;
                        end else begin
                            state_next = ST_PREBOOST;
                        end
                    end
                end
                ST_PREBOOST: begin
                    if (!en_f || shutdown_req) begin
                        state_next = ST_SOFT_OFF;
                    end else if (!demand) begin
                        state_next = ST_OFF;
                    end else if (phase_cnt_reg >= PRB_LAST) begin
                        state_next = ST_ON;
                    end
                end
                ST_ON: begin
                    if (!en_f || shutdown_req) begin
                        state_next = ST_SOFT_OFF;
                    end else if (!demand) begin
                        if (tl_enabled) begin
                            state_next = ST_TWO_LEVEL;
                        end else begin
                            state_next = ST_OFF;
                        end
                    end
                end
                ST_TWO_LEVEL: begin
                    if (!en_f || shutdown_req) begin
                        state_next = ST_SOFT_OFF;
                    end else if (phase_cnt_reg >= TL_LAST) begin
                        state_next = ST_OFF;
                    end
                end
                ST_SOFT_OFF: begin
                    if (!shutdown_req && !demand) begin
                        state_next = ST_OFF;
                    end
                end
                default: begin
                    state_next = ST_OFF;
                end
            endcase
        end
        if (state_next != state_reg) begin
            phase_cnt_next = '0;
        end else if (phase_cnt_reg == '1) begin
            phase_cnt_next = phase_cnt_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_OFF;
            phase_cnt_reg <= '0;
        end else begin
            state_reg     <= state_next;
            phase_cnt_reg <= phase_cnt_next;
        end
    end

    // gate current setting carried across the barrier
    logic [SPEED_W-1:0] speed_xfer_reg, speed_xfer_next;

    always_comb begin
        speed_xfer_next = speed_xfer_reg;
        if (speed_sample_valid) begin
            speed_xfer_next = speed_sample;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_xfer_reg <= '0;
        end else begin
            speed_xfer_reg <= speed_xfer_next;
        end
    end

    // registered outputs
    logic               gate_on_reg, gate_on_next;
    logic               preboost_reg, preboost_next;
    logic               normal_off_reg, normal_off_next;
    logic               soft_off_reg, soft_off_next;
    logic               two_level_reg, two_level_next;
    igd_plateau_type    plateau_reg, plateau_next;
    logic [LEVEL_W-1:0] level_reg, level_next;
    logic               fault_oe_reg, fault_oe_next;
    logic               pri_oe_reg, pri_oe_next;
    logic               sec_oe_reg, sec_oe_next;

    always_comb begin
        gate_on_next    = (state_next == ST_ON) || (state_next == ST_PREBOOST);
        preboost_next   = (state_next == ST_PREBOOST);
        normal_off_next = (state_next == ST_OFF);
        soft_off_next   = (state_next == ST_SOFT_OFF);
        two_level_next  = (state_next == ST_TWO_LEVEL);
        plateau_next    = plateau_from_strap({pins_s[SY_VZ_HI], pins_s[SY_VZ_LO]});
        level_next      = speed_to_level(speed_xfer_reg);
        fault_oe_next   = fault_next;
        pri_oe_next     = ~(pins_s[SY_CORE_OK] & pins_s[SY_LREF_OK]);
        sec_oe_next     = ~(pins_s[SY_SEC_OK] & pins_s[SY_LINK_OK]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_on_reg    <= 1'b0;
            preboost_reg   <= 1'b0;
            normal_off_reg <= 1'b1;
            soft_off_reg   <= 1'b0;
            two_level_reg  <= 1'b0;
            plateau_reg    <= PL_10V3;
            level_reg      <= LEVEL_W'(SPEED_LEVELS);
            fault_oe_reg   <= 1'b0;
            pri_oe_reg     <= 1'b1;
            sec_oe_reg     <= 1'b1;
        end else begin
            gate_on_reg    <= gate_on_next;
            preboost_reg   <= preboost_next;
            normal_off_reg <= normal_off_next;
            soft_off_reg   <= soft_off_next;
            two_level_reg  <= two_level_next;
            plateau_reg    <= plateau_next;
            level_reg      <= level_next;
            fault_oe_reg   <= fault_oe_next;
            pri_oe_reg     <= pri_oe_next;
            sec_oe_reg     <= sec_oe_next;
        end
    end

    // open-drain pins only ever pull low
    logic od_low_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            od_low_reg <= 1'b0;
        end else begin
            od_low_reg <= 1'b0;
        end
    end

    assign gate_on_out         = gate_on_reg;
    assign preboost_out        = preboost_reg;
    assign normal_off_out      = normal_off_reg;
    assign soft_shutdown_out   = soft_off_reg;
    assign two_level_out       = two_level_reg;
    assign plateau_sel         = plateau_reg;
    assign gate_level          = level_reg;
    assign fault_out_n_out     = od_low_reg;
    assign fault_out_n_oe      = fault_oe_reg;
    assign primary_ready_out   = od_low_reg;
    assign primary_ready_oe    = pri_oe_reg;
    assign secondary_ready_out = od_low_reg;
    assign secondary_ready_oe  = sec_oe_reg;

endmodule : igd_gate_ctrl

`default_nettype wire

// ### verif/igd_gate_ctrl_properties.sv
// igd_gate_ctrl_properties: port checks of the gate drive control
// assumes bind to igd_gate_ctrl, one clock, async active-low reset
`default_nettype none

module igd_gate_ctrl_properties
    import igd_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire logic                        primary_core_supply,
    input wire logic                        logic_ref_supply,
    input wire logic                        secondary_undervoltage_level,
    input wire logic                        barrier_link_ok,
    input wire logic                        protect_inhibit,
    input wire logic [1:0]                  two_level_voltage_strap,
    input wire logic                        gate_on_out,
    input wire logic                        preboost_out,
    input wire logic                        normal_off_out,
    input wire logic                        soft_shutdown_out,
    input wire logic                        two_level_out,
    input wire igd_pkg::igd_plateau_type    plateau_sel,
    input wire logic [igd_pkg::LEVEL_W-1:0] gate_level,
    input wire logic                        fault_out_n_out,
    input wire logic                        fault_out_n_oe,
    input wire logic                        primary_ready_out,
    input wire logic                        primary_ready_oe,
    input wire logic                        secondary_ready_out,
    input wire logic                        secondary_ready_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] warm_reg;
    logic [1:0] warm_next;
    // cycles since reset release, saturating
    always_comb warm_next = (warm_reg == 2'h3) ? warm_reg : warm_reg + 2'h1;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) warm_reg <= 2'h0;
        else warm_reg <= warm_next;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence boost_run;
        preboost_out [*3] ##1 !preboost_out;
    endsequence
    chk_od_data: assert property (
        !(fault_out_n_out || primary_ready_out || secondary_ready_out)) else $error("od data");
    chk_state_onehot: assert property (
        $onehot({normal_off_out, gate_on_out, two_level_out, soft_shutdown_out})
        && (!preboost_out || gate_on_out)) else $error("state");
    chk_boost_len: assert property ($rose(preboost_out) |-> boost_run)
        else $error("boost");
    chk_uv_off: assert property (
        (primary_ready_oe || secondary_ready_oe) |-> ##[0:2] !gate_on_out) else $error("uv");
    chk_fault_soft: assert property (
        $rose(fault_out_n_oe) && $past(gate_on_out) && !protect_inhibit |-> soft_shutdown_out)
        else $error("soft");
    chk_primary_ready_follow: assert property (warm_reg == 2'h3 |-> primary_ready_oe ==
        !($past(primary_core_supply, 3) && $past(logic_ref_supply, 3))) else $error("primary_ready");
    chk_secondary_ready_follow: assert property (warm_reg == 2'h3 |-> secondary_ready_oe ==
        !($past(secondary_undervoltage_level, 3) && $past(barrier_link_ok, 3)))
        else $error("secondary_ready");
    chk_plateau_strap: assert property (
        (warm_reg == 2'h3 && two_level_voltage_strap == 2'h0) [*5] |-> plateau_sel == PL_9V3)
        else $error("plateau");
    chk_level_range: assert property (gate_level inside {[4'h1:4'hB]})
        else $error("level");
endmodule : igd_gate_ctrl_properties

`default_nettype wire

// ### verif/igd_host_model.sv
// igd_host_model: host controller driving the drive and enable pins
// assumes requests change at the rising edge; pins follow one edge later
`default_nettype none

module igd_host_model (
    input  wire logic       clk,
    input  wire logic       float_req,
    input  wire logic [2:0] req,
    output var  logic       drive_in_noninv = 1'b0,
    output var  logic       drive_in_inv    = 1'b1,
    output var  logic       enable_in       = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // req holds noninv, inv, enable; float leaves the drive pins open
    always @(posedge clk) begin
        drive_in_noninv <= req[2] && !float_req;
        drive_in_inv <= req[1] || float_req;
        enable_in <= req[0];
    end
endmodule : igd_host_model

`default_nettype wire

// ### verif/tb_top.sv
// tb_top: self-checking bench of the gate drive control
// assumes host model on the drive pins, 20 MHz clock, checker bound below
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import igd_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, float_req = 1'b1;
    logic saturation_monitor = 1'b0, overcurrent_sense = 1'b0, protect_inhibit = 1'b0;
    logic overcurrent_sense_grounded = 1'b0, two_level_time_cap = 1'b0;
    logic speed_sample_valid = 1'b0;
    logic [1:0] two_level_voltage_strap = 2'h2;
    logic [2:0] req = 3'h0, seen = 3'h0;
    logic [3:0] sup = 4'hF;
    logic [SPEED_W-1:0] speed_sample = 8'h00;
    logic [CNT_W-1:0] saturation_monitor_filter_cycles = 8'h02;
    wire logic drive_in_noninv, drive_in_inv, enable_in, primary_core_supply;
    wire logic logic_ref_supply, secondary_undervoltage_level, barrier_link_ok;
    logic gate_on_out, preboost_out, normal_off_out, soft_shutdown_out, two_level_out;
    logic fault_out_n_out, fault_out_n_oe, primary_ready_out, primary_ready_oe;
    logic secondary_ready_out, secondary_ready_oe;
    logic [LEVEL_W-1:0] gate_level;
    igd_plateau_type plateau_sel;
    igd_plateau_type pl [4] = '{PL_9V3, PL_11V4, PL_10V3, PL_10V3};
    // float, noninv, inv, enable | gate on, soft, preboost seen, two-level seen
    logic [7:0] rows [11] = '{8'h90, 8'h5A, 8'h71, 8'h5A, 8'h11, 8'h5A, 8'h44, 8'h10,
                              8'h00, 8'h40, 8'h58};
    int errors = 0, comparisons = 0;

    igd_host_model host (.*);
    igd_gate_ctrl #(.TL_DELAY(4)) dut (.*);
    assign {barrier_link_ok, secondary_undervoltage_level, logic_ref_supply,
            primary_core_supply} = sup;

    always #25 clk = ~clk;
    always @(posedge clk) seen <= clr ? 3'h0 : seen | {soft_shutdown_out, preboost_out,
                                                       two_level_out};

    task automatic go(input int n);
        clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        repeat (n - 1) @(posedge clk);
    endtask : go
    task automatic look(input int n);
        go(n);
        @(negedge clk);
    endtask : look
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
        @(posedge clk);
    endtask : chk
    task automatic close_out;
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            {float_req, req} <= rows[i][7:4];
            look(22);
            chk({4'h0, gate_on_out, soft_shutdown_out, seen[1:0]}, {4'h0, rows[i][3:0]});
        end
        for (int k = 0; k < 2; k++) begin
            req <= (k == 0) ? 3'h7 : 3'h4;
            @(posedge clk);
            req <= 3'h5;
            look(20);
            chk({4'h0, gate_on_out, seen}, 8'h08);
        end
        for (int i = 0; i < 4; i++) begin
            sup <= 4'hF ^ (4'h1 << i);
            look(12);
            chk({5'h0, gate_on_out, primary_ready_oe, secondary_ready_oe}, {6'h0, i < 2, i >= 2});
            sup <= 4'hF;
            go(22);
        end
        {overcurrent_sense_grounded, overcurrent_sense} <= 2'h3;
        look(12);
        chk({7'h0, fault_out_n_oe}, 8'h00);
        {overcurrent_sense_grounded, overcurrent_sense, saturation_monitor} <= 3'h1;
        go(12);
        saturation_monitor <= 1'b0;
        look(30);
        chk({5'h0, gate_on_out, soft_shutdown_out, fault_out_n_oe}, 8'h03);
        for (int k = 12; k <= 25; k += 13) begin
            req <= 3'h4;
            go(k);
            req <= 3'h5;
            look(20);
            chk({7'h0, fault_out_n_oe}, {7'h0, k < 18});
        end
        req <= 3'h1;
        go(20);
        req <= 3'h5;
        go(20);
        {protect_inhibit, overcurrent_sense} <= 2'h3;
        go(12);
        overcurrent_sense <= 1'b0;
        look(10);
        chk({5'h0, gate_on_out, soft_shutdown_out, fault_out_n_oe}, 8'h05);
        two_level_time_cap <= 1'b1;
        req <= 3'h1;
        look(20);
        chk({4'h0, gate_on_out, seen}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            two_level_voltage_strap <= 2'(i);
            speed_sample <= i[0] ? 8'hFF : 8'h00;
            speed_sample_valid <= 1'b1;
            look(8);
            chk({2'h0, plateau_sel, gate_level}, {2'h0, pl[i], i[0] ? 4'h1 : 4'hB});
        end
        close_out;
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        close_out;
    end
endmodule : tb_top

bind igd_gate_ctrl igd_gate_ctrl_properties chk_i (.*);

`default_nettype wire
